// *** rtl/synth_host.sv ***
// host end: wishbone registers driving the three-wire programming link
`timescale 1ns/1ps
`default_nettype none
`include "synth_defs.svh"

module synth_host
    import synth_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    synth_link_if.host       lnk
);
    localparam logic [7:0] HALF = 8'(`SCLK_HALF_CYC);
    localparam logic [7:0] HOLD = 8'(`LE_HOLD_CYC);

    host_state_t s_q;
    host_state_t s_d;
    logic        lock_s;
    logic [31:0] wr;
    logic        is_ref;
    logic        ok;

    // byte-lane merge of write data over an old register value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    sync2 #(.W(1)) u_lock (
        .clk  (MCLK),
        .rstn (RSTN),
        .d    (lnk.lock_indicate),
        .q    (lock_s)
    );

    // ==========================================
    // bus slave and link sequencer
    always_comb begin
        s_d    = s_q;
        wr     = 32'h0000_0000;
        is_ref = 1'h0;
        ok     = 1'h0;
        s_d.le_oe = 1'h1;

        // one-wait-state slave; a write lands only at the edge that samples ack
        s_d.ack = 1'h0;
        if (WB_CYC_I && WB_STB_I) begin
            s_d.ack = !s_q.ack;
            if (!s_q.ack) begin
                s_d.dat_o = 32'h0000_0000;
            end
            if (WB_WE_I && s_q.ack) begin
                case (WB_ADR_I)
                    `REG_TX: begin
                        wr     = merge({13'h0000, s_q.tx_word}, WB_DAT_I, WB_SEL_I);
                        is_ref = wr[`CTRL_BIT];
                        // refuse out-of-range settings before they reach the link
                        ok     = is_ref ? (wr[`REF_CNT_MSB:`REF_CNT_LSB] >= `REF_MIN)
                                        : (wr[`SWAL_MSB:`SWAL_LSB] <= `SWAL_MAX &&
                                           wr[`MAIN_MSB:`MAIN_LSB] >= `MAIN_MIN);
                        ok     = ok && (s_q.st == H_IDLE);
                        s_d.rej = !ok;
                        if (ok) begin
                            s_d.tx_word = wr[18:0];
                            // reference words are 16 bits; align to the top for msb first
                            s_d.shw   = is_ref ? (wr[18:0] << `REF_ALIGN) : wr[18:0];
                            s_d.bits  = is_ref ? `REF_BITS : `MAIN_BITS;
                            s_d.sdata = s_d.shw[18];
                            s_d.div   = 8'h00;
                            s_d.st    = H_LOW;
                        end
                    end
                    `REG_CTRL: begin
                        wr          = merge({30'h0000_0000, s_q.fc_open, s_q.fc_lvl},
                                            WB_DAT_I, WB_SEL_I);
                        s_d.fc_lvl  = wr[0];
                        s_d.fc_open = wr[1];
                    end
                    default: begin
                    end
                endcase
            end else if (!WB_WE_I && !s_q.ack) begin
                case (WB_ADR_I)
                    `REG_TX:     s_d.dat_o = {13'h0000, s_q.tx_word};
                    `REG_CTRL:   s_d.dat_o = {30'h0000_0000, s_q.fc_open, s_q.fc_lvl};
                    `REG_STATUS: s_d.dat_o = {29'h0000_0000, s_q.rej, lock_s,
                                              s_q.st != H_IDLE};
                    default:     s_d.dat_o = 32'h0000_0000;
                endcase
            end
        end

        // serial clock made by dividing MCLK; data changes only while it is low
        case (s_q.st)
            H_IDLE: begin
                s_d.sclk = 1'h0;
                s_d.le_o = 1'h0;
            end
            H_LOW: begin
                s_d.div = s_q.div + 8'h01;
                if (s_q.div >= HALF - 8'h01) begin
                    s_d.div  = 8'h00;
                    s_d.sclk = 1'h1;
                    s_d.st   = H_HIGH;
                end
            end
            H_HIGH: begin
                s_d.div = s_q.div + 8'h01;
                if (s_q.div >= HALF - 8'h01) begin
                    s_d.div  = 8'h00;
                    s_d.sclk = 1'h0;
                    if (s_q.bits <= 5'h01) begin
                        // strobe only after the select bit has gone in last
                        s_d.le_o = 1'h1;
                        s_d.st   = H_LOAD;
                    end else begin
                        s_d.bits  = s_q.bits - 5'h01;
                        s_d.shw   = {s_q.shw[17:0], 1'h0};
                        s_d.sdata = s_q.shw[17];
                        s_d.st    = H_LOW;
                    end
                end
            end
            H_LOAD: begin
                s_d.div = s_q.div + 8'h01;
                if (s_q.div >= HOLD - 8'h01) begin
                    s_d.div  = 8'h00;
                    s_d.le_o = 1'h0;
                    s_d.st   = H_IDLE;
                end
            end
            default: begin
                s_d.st = H_IDLE;
            end
        endcase
    end

    // ==========================================
    // state register
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            s_q        <= '0;
            s_q.st     <= H_IDLE;
            s_q.fc_lvl <= 1'h1;
        end else begin
            s_q <= s_d;
        end
    end

    assign WB_DAT_O  = s_q.dat_o;
    assign WB_ACK_O  = s_q.ack;
    assign lnk.sclk  = s_q.sclk;
    assign lnk.sdata = s_q.sdata;
    assign lnk.le_o  = s_q.le_o;
    assign lnk.le_oe = s_q.le_oe;
    assign lnk.fc_o  = s_q.fc_lvl;
    assign lnk.fc_oe = !s_q.fc_open;
endmodule

`default_nettype wire

// *** rtl/synth_defs.svh ***
// offsets, field positions, reset values and timing counts of the synthesizer link
`ifndef SYNTH_DEFS_SVH
`define SYNTH_DEFS_SVH

// ==========================================
// serial word layout (bit 0 arrives last)
`define CTRL_BIT      0
`define REF_CNT_LSB   1
`define REF_CNT_MSB   14
`define MODSEL_BIT    15
`define SWAL_LSB      1
`define SWAL_MSB      7
`define MAIN_LSB      8
`define MAIN_MSB      18
`define SH_W          19
`define REF_BITS      5'h10
`define MAIN_BITS     5'h13
`define REF_ALIGN     3

// ==========================================
// programming limits
`define REF_MIN       14'h0008
`define MAIN_MIN      11'h010
`define SWAL_MAX      7'h3F

// ==========================================
// prescaler moduli (smaller modulus of each pair)
`define MOD_SMALL     7'h20
`define MOD_LARGE     7'h40

// ==========================================
// latch reset values
`define REF_RST       14'h0008
`define MODSEL_RST    1'h1
`define SWAL_RST      7'h00
`define MAIN_RST      11'h010

// ==========================================
// host register byte offsets
`define REG_TX        8'h00
`define REG_CTRL      8'h04
`define REG_STATUS    8'h08

// ==========================================
// host timing
`define MCLK_NS       40
`define SCLK_HALF_NS  160
`define LE_HOLD_NS    320
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `MCLK_NS - 1) / `MCLK_NS)
`define LE_HOLD_CYC   ((`LE_HOLD_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// *** rtl/synth_pkg.sv ***
// types shared by both ends of the synthesizer link
`default_nettype none
`include "synth_defs.svh"

package synth_pkg;

    // ==========================================
    // device state
    typedef struct packed {
        logic [18:0] sh;
        logic [13:0] ref_n;
        logic        modsel;
        logic [6:0]  swal_n;
        logic [10:0] main_n;
        logic [13:0] r_left;
        logic [6:0]  pre_cnt;
        logic [6:0]  a_left;
        logic [10:0] n_left;
        logic        sclk_d;
        logic        ref_d;
        logic        pre_d;
        logic        fr;
        logic        fp;
        logic        up;
        logic        dn;
        logic        lock;
        logic        pump_o;
        logic        pump_oe;
        logic        ph_r;
        logic        ph_p_oe;
        logic        mon;
        logic        fl_o;
        logic        fl_oe;
    } dev_state_t;

    // ==========================================
    // host sequencer
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_LOAD} host_fsm_t;

    typedef struct packed {
        host_fsm_t   st;
        logic [7:0]  div;
        logic [4:0]  bits;
        logic [18:0] shw;
        logic [18:0] tx_word;
        logic        fc_lvl;
        logic        fc_open;
        logic        rej;
        logic        ack;
        logic [31:0] dat_o;
        logic        sclk;
        logic        sdata;
        logic        le_o;
        logic        le_oe;
    } host_state_t;

endpackage

`default_nettype wire

// *** rtl/synth_link_if.sv ***
// three-wire programming link plus polarity and lock lines between host and device
`timescale 1ns/1ps
`default_nettype none

interface synth_link_if;
    logic sclk;
    logic sdata;
    logic le_o;
    logic le_oe;
    logic fc_o;
    logic fc_oe;
    logic load_strobe;
    logic phase_polarity_sel;
    logic lock_indicate;

    // internal pull-ups: an undriven strobe or polarity line reads high
    assign load_strobe        = le_oe ? le_o : 1'h1;
    assign phase_polarity_sel = fc_oe ? fc_o : 1'h1;

    modport host (
        output sclk,
        output sdata,
        output le_o,
        output le_oe,
        output fc_o,
        output fc_oe,
        input  lock_indicate
    );

    modport dev (
        input  sclk,
        input  sdata,
        input  load_strobe,
        input  phase_polarity_sel,
        output lock_indicate
    );
endinterface

`default_nettype wire

// *** rtl/sync2.sv ***
// two-flop synchroniser for levels arriving from another clock domain
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // ==========================================
    // first stage feeds only the second
    always_comb begin
        s_d    = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule

`default_nettype wire

// *** rtl/synth_device.sv ***
// serial-programmed synthesizer: shift register, latches, dividers, phase detector
// What this block does
// - each serial clock rise shifts one data bit
// - last bit shifted selects destination latch
// - select 1 with strobe high loads reference
// - select 0 with strobe high loads main
// - open strobe reads high and transfers
// - strobe high routes pump to fast-lock
// - strobe low floats fast-lock output
// - polarity low inverts pump and phase outputs
// - polarity selects monitor: reference or feedback
// - lock line low while phases differ
// - phase pull-down only sinks or floats
// - swallow count 7 bits, program 0..63
// - main count 11 bits, program 16..2047
// - reference count 14 bits, program 8..16383
// - modulus bit picks 32/33 or 64/65
// - modulus bit 1 means 32/33
// - host sends words most significant first
// - reference word: 14 count, modulus, 1
// - main word: 7 swallow, 11 count, 0
`timescale 1ns/1ps
`default_nettype none
`include "synth_defs.svh"

module synth_device
    import synth_pkg::*;
(
    input  wire logic MCLK,
    input  wire logic RSTN,
    input  wire logic REF_OSC_INPUT,
    input  wire logic PRESCALER_INPUT,
    output logic      PUMP_O,
    output logic      PUMP_OE,
    output logic      PHASE_R,
    output logic      PHASE_P_O,
    output logic      PHASE_P_OE,
    output logic      MONITOR,
    output logic      FAST_LOCK_OUT_O,
    output logic      FAST_LOCK_OUT_OE,
    synth_link_if.dev lnk
);
    localparam dev_state_t DEV_RST = '{
        sh: '0, ref_n: `REF_RST, modsel: `MODSEL_RST, swal_n: `SWAL_RST,
        main_n: `MAIN_RST, r_left: `REF_RST, pre_cnt: '0, a_left: `SWAL_RST,
        n_left: `MAIN_RST, lock: 1'h1, default: '0};

    dev_state_t s_q;
    dev_state_t s_d;
    logic [5:0] pins;
    logic       sclk_s;
    logic       sdata_s;
    logic       le_s;
    logic       fc_s;
    logic       ref_s;
    logic       pre_s;
    logic [6:0] pre_lim;
    logic       pre_out;

    // ==========================================
    // pin synchronisers
    // every pin comes from outside MCLK, so all pass two flops first
    sync2 #(.W(6)) u_sync (
        .clk  (MCLK),
        .rstn (RSTN),
        .d    ({lnk.sclk, lnk.sdata, lnk.load_strobe, lnk.phase_polarity_sel,
                REF_OSC_INPUT, PRESCALER_INPUT}),
        .q    (pins)
    );

    assign {sclk_s, sdata_s, le_s, fc_s, ref_s, pre_s} = pins;

    // ==========================================
    // next-state logic
    always_comb begin
        s_d         = s_q;
        s_d.sclk_d  = sclk_s;
        s_d.ref_d   = ref_s;
        s_d.pre_d   = pre_s;
        s_d.fr      = 1'h0;
        s_d.fp      = 1'h0;
        pre_out     = 1'h0;
        pre_lim     = 7'h00;

        // shift in on the synchronised serial clock rise
        if (sclk_s && !s_q.sclk_d) begin
            s_d.sh = {s_q.sh[17:0], sdata_s};
        end

        // strobe is level sensitive; pulled high when open it keeps loading
        if (le_s) begin
            if (s_q.sh[`CTRL_BIT]) begin
                s_d.ref_n  = s_q.sh[`REF_CNT_MSB:`REF_CNT_LSB];
                s_d.modsel = s_q.sh[`MODSEL_BIT];
            end else begin
                s_d.swal_n = s_q.sh[`SWAL_MSB:`SWAL_LSB];
                s_d.main_n = s_q.sh[`MAIN_MSB:`MAIN_LSB];
            end
        end

        // reference divider, one pulse every ref_n oscillator edges
        if (ref_s && !s_q.ref_d) begin
            if (s_q.r_left <= 14'h0001) begin
                s_d.r_left = s_q.ref_n;
                s_d.fr     = 1'h1;
            end else begin
                s_d.r_left = s_q.r_left - 14'h0001;
            end
        end

        // dual-modulus prescaler: count 0..lim, larger modulus while swallowing
        pre_lim = s_q.modsel ? `MOD_SMALL : `MOD_LARGE;
        if (s_q.a_left == 7'h00) begin
            pre_lim = pre_lim - 7'h01;
        end
        if (pre_s && !s_q.pre_d) begin
            if (s_q.pre_cnt >= pre_lim) begin
                s_d.pre_cnt = 7'h00;
                pre_out     = 1'h1;
            end else begin
                s_d.pre_cnt = s_q.pre_cnt + 7'h01;
            end
        end

        // swallow and main counters share each prescaler cycle
        if (pre_out) begin
            if (s_q.n_left <= 11'h001) begin
                s_d.n_left = s_q.main_n;
                s_d.a_left = s_q.swal_n;
                s_d.fp     = 1'h1;
            end else begin
                s_d.n_left = s_q.n_left - 11'h001;
                if (s_q.a_left != 7'h00) begin
                    s_d.a_left = s_q.a_left - 7'h01;
                end
            end
        end

        // three-state phase detector; coincident edges cancel
        s_d.up = s_q.up | s_d.fr;
        s_d.dn = s_q.dn | s_d.fp;
        if (s_d.up && s_d.dn) begin
            s_d.up = 1'h0;
            s_d.dn = 1'h0;
        end

        s_d.lock    = !(s_d.up || s_d.dn);
        s_d.pump_oe = s_d.up ^ s_d.dn;
        s_d.pump_o  = fc_s ? s_d.up : s_d.dn;
        s_d.ph_r    = fc_s ? s_d.dn : s_d.up;
        s_d.ph_p_oe = fc_s ? s_d.up : s_d.dn;
        s_d.mon     = fc_s ? s_d.fr : s_d.fp;

        // fast-lock switch closed only while the strobe is high
        s_d.fl_o  = s_d.pump_o;
        s_d.fl_oe = le_s && s_d.pump_oe;
    end

    // ==========================================
    // state register
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            s_q <= DEV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // outputs straight from the state register, except PHASE_P_O which is tied low
    assign PUMP_O            = s_q.pump_o;
    assign PUMP_OE           = s_q.pump_oe;
    assign PHASE_R           = s_q.ph_r;
    assign PHASE_P_O         = 1'h0; // open drain never drives high
    assign PHASE_P_OE        = s_q.ph_p_oe;
    assign MONITOR           = s_q.mon;
    assign FAST_LOCK_OUT_O   = s_q.fl_o;
    assign FAST_LOCK_OUT_OE  = s_q.fl_oe;
    assign lnk.lock_indicate = s_q.lock;
endmodule

`default_nettype wire

// *** verification/synth_link_assertions.sv ***
// protocol checker watching the host-to-device programming wires
`timescale 1ns/1ps
`default_nettype none

module synth_link_assertions (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic le_o,
    input wire logic le_oe
);
    logic       sclk_q;
    logic [4:0] cnt_q;
    logic       last_q;

    // ==========================================
    // bits shifted since the last strobe; cleared under the strobe
    always_ff @(posedge MCLK) begin
        sclk_q <= RSTN & sclk;
        if (!RSTN || le_o) begin
            cnt_q <= 5'h00;
        end else if (sclk && !sclk_q) begin
            cnt_q  <= cnt_q + 5'h01;
            last_q <= sdata; // last captured bit steers the latch
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    // ==========================================
    // named steps of one bit and one strobe
    sequence seq_high4;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence seq_strobe8;
        le_o [*8] ##1 !le_o;
    endsequence

    AST_SCLK_HIGH: assert property ($rose(sclk) |-> seq_high4)
        else $error("serial clock high phase not four cycles");
    AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("serial clock low phase too short");
    AST_SDATA_STABLE: assert property (sclk && $past(sclk) |-> $stable(sdata))
        else $error("data moved while serial clock high");
    AST_LE_NO_SCLK: assert property (le_o |-> !sclk)
        else $error("strobe raised during shifting");
    AST_LE_HOLD: assert property ($rose(le_o) |-> seq_strobe8)
        else $error("strobe width not eight cycles");
    AST_WORD_LEN: assert property ($rose(le_o) |-> cnt_q == 5'h10 || cnt_q == 5'h13)
        else $error("word length neither 16 nor 19");
    AST_DEST_BIT: assert property ($rose(le_o) |-> last_q == (cnt_q == 5'h10))
        else $error("destination bit does not match word length");
    AST_LE_DRIVEN: assert property ($past(RSTN) |-> le_oe)
        else $error("strobe left floating out of reset");
endmodule

`default_nettype wire

// *** verification/serial_pll_divider_control_tb.sv ***
// self-checking bench joining host and device over the programming link
`timescale 1ns/1ps
`default_nettype none
`include "synth_defs.svh"

module serial_pll_divider_control_tb;
    logic        MCLK = 1'h0;
    logic        RSTN = 1'h0;
    logic        cyc  = 1'h0;
    logic        stb  = 1'h0;
    logic        we   = 1'h0;
    logic        osc  = 1'h0;
    logic        pre  = 1'h0;
    logic [7:0]  adr  = 8'h00;
    logic [3:0]  sel  = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack, pump_o, pump_oe, ph_r, ph_p_o, ph_p_oe, mon, fl_o, fl_oe;
    logic        ms, osc_en = 1'h0, pre_en = 1'h0, sel_pre = 1'h0;
    int          bad_count = 0, n_checks = 0, seed = 32'h0c93d062;
    int          ph = 0, osc_n = 0, pre_n = 0, mon_n = 0, mon_prev = 0, mon_last = 0;
    int          i, r, n, a;

    synth_link_if u_synth_link_if ();
    synth_host u_synth_host (.MCLK(MCLK), .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .lnk(u_synth_link_if));
    synth_device u_synth_device (.MCLK(MCLK), .RSTN(RSTN), .REF_OSC_INPUT(osc),
        .PRESCALER_INPUT(pre), .PUMP_O(pump_o), .PUMP_OE(pump_oe), .PHASE_R(ph_r),
        .PHASE_P_O(ph_p_o), .PHASE_P_OE(ph_p_oe), .MONITOR(mon), .FAST_LOCK_OUT_O(fl_o),
        .FAST_LOCK_OUT_OE(fl_oe), .lnk(u_synth_link_if));
    synth_link_assertions u_synth_link_assertions (.MCLK(MCLK), .RSTN(RSTN),
        .sclk(u_synth_link_if.sclk), .sdata(u_synth_link_if.sdata),
        .le_o(u_synth_link_if.le_o), .le_oe(u_synth_link_if.le_oe));

    // ==========================================
    // clock, oscillator and prescaler edges, monitor pulse log
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    // levels held three cycles so the device synchronisers see each one
    always @(posedge MCLK) begin
        ph <= (ph == 2) ? 0 : ph + 1;
        if (ph == 2 && osc_en) begin
            osc   <= ~osc;
            osc_n <= osc_n + !osc;
        end
        if (ph == 2 && pre_en) begin
            pre   <= ~pre;
            pre_n <= pre_n + !pre;
        end
        if (mon === 1'h1) begin
            mon_prev <= mon_last;
            mon_last <= sel_pre ? pre_n : osc_n;
            mon_n    <= mon_n + 1;
        end
    end

    // ==========================================
    // shared tasks and expectations
    function automatic logic [18:0] ref_w(input logic m, input logic [13:0] c);
        return {3'h0, m, c, 1'h1};
    endfunction
    function automatic logic [18:0] main_w(input logic [10:0] c, input logic [6:0] s);
        return {c, s, 1'h0};
    endfunction
    function automatic int fb_len(input logic m, input int c, input int s);
        return (m ? 32'h20 : 32'h40) * c + s;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; held until ack is sampled high
    task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= ad;
        wdat <= d;
        @(posedge MCLK);
        // no cycle count assumed; only the watchdog ends a hung wait
        while (ack !== 1'h1) begin
            @(posedge MCLK);
        end
        rdat = dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge MCLK);
    endtask

    task send(input logic [18:0] w, input logic ok);
        int t;
        t = 0;
        wb(1'h1, `REG_TX, {13'h0, w});
        wb(1'h0, `REG_STATUS, 32'h0);
        chk(rdat[2], !ok);
        if (ok) begin
            while (u_synth_link_if.load_strobe !== 1'h1 && t < 400) begin
                @(posedge MCLK);
                t++;
            end
            chk(u_synth_link_if.load_strobe, 1'h1);
            repeat (4) @(posedge MCLK);
            chk(fl_oe, 1'h1);
            chk(fl_o, pump_o);
            while (rdat[0] !== 1'h0 && t < 500) begin
                wb(1'h0, `REG_STATUS, 32'h0);
                t++;
            end
            chk(rdat[0], 1'h0);
            repeat (4) @(posedge MCLK);
            chk(fl_oe, 1'h0);
        end
    endtask

    // period between the last two monitor pulses, after the new setting settled
    task meas(input logic p, input int exp);
        int t, m0;
        t = 0;
        sel_pre = p;
        m0 = mon_n;
        while (mon_n < m0 + 3 && t < 40000) begin
            @(posedge MCLK);
            t++;
        end
        chk(mon_n - m0, 3);
        chk(mon_last - mon_prev, exp);
        chk({pump_oe, pump_o, ph_r, ph_p_oe, ph_p_o}, 5'h1A);
        chk(u_synth_link_if.lock_indicate, 1'h0);
    endtask

    task complete_run;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog sized well above the longest divider measurement
    initial begin
        #3600000;
        bad_count++;
        complete_run;
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (5) @(posedge MCLK);
        RSTN <= 1'h1;
        @(posedge MCLK);
        chk(u_synth_link_if.lock_indicate, 1'h1);
        wb(1'h0, `REG_CTRL, 32'h0);
        chk(rdat[1:0], 2'h1);
        wb(1'h1, 8'h0C, 32'hFFFFFFFF);
        wb(1'h0, 8'h0C, 32'h0);
        chk(rdat, 32'h0);
        // out-of-range words are refused and never reach the wire
        send(ref_w(1'h1, 14'h0007), 1'h0);
        send(main_w(11'h010, 7'h40), 1'h0);
        send(main_w(11'h00F, 7'h00), 1'h0);
        // reference running early so the pump drives during the first strobe
        osc_en = 1'h1;
        for (i = 0; i < 2; i++) begin
            ms = i[0];
            r = i ? 8 + ($random(seed) & 31) : 8;
            n = 16 + ($random(seed) & 7);
            a = i ? ($random(seed) & 15) : 0;
            // second pass leaves polarity floating, which must read high
            wb(1'h1, `REG_CTRL, i ? 32'h2 : 32'h1);
            repeat (3) @(posedge MCLK);
            chk(u_synth_link_if.phase_polarity_sel, 1'h1);
            send(ref_w(ms, r[13:0]), 1'h1);
            pre_en = 1'h0;
            osc_en = 1'h1;
            meas(1'h0, r);
            send(main_w(n[10:0], a[6:0]), 1'h1);
            wb(1'h1, `REG_CTRL, 32'h0);
            osc_en = 1'h0;
            pre_en = 1'h1;
            meas(1'h1, fb_len(ms, n, a));
            wb(1'h0, `REG_STATUS, 32'h0);
            chk(rdat[1], 1'h0);
        end
        complete_run;
    end
endmodule

`default_nettype wire
